// ===== rtl/chip_reset_control_params.svh
/*
 * constants of the chip reset controller: register offsets,
 * field positions, reset values and counts.
 * assumes a 50 MHz ref_clk and byte addresses on the register port.
 */
// Behaviour
// R1 - reset from pin, watchdog or software
// R2 - software avoids reset request in slow mode
// R3 - driver holds pin low through supply settling
// R4 - pin low twelve clocks gives warm reset
// R5 - warm reset only with stable supply, oscillator
// R6 - warm reset restores core control registers
// R7 - debug, cause, security kept through warm reset
// R8 - pll multiplier off after any reset
// R9 - execution starts at reset vector routine
// R10 - ram contents not preserved across reset
// R11 - debug traffic refused while pin held
// R12 - probe sets breakpoints then resets by software
// R13 - five debug pins default to debug function
// R14 - software careful reassigning debug pins early
// R15 - watchdog stops while core halted
// R16 - synchronise pin, merge sources, record cause
`ifndef CHIP_RESET_CONTROL_PARAMS_SVH
`define CHIP_RESET_CONTROL_PARAMS_SVH

`define ADDR_CONTROL    8'h00
`define ADDR_CAUSE      8'h04
`define ADDR_SECURITY   8'h08
`define ADDR_STATUS     8'h0c

`define CTRL_PLL_BIT    0
`define CTRL_PINS_LSB   4
`define CTRL_PINS_MSB   8
`define PINS_RESET      5'h1f

`define CAUSE_PIN_BIT   0
`define CAUSE_WDT_BIT   1
`define CAUSE_SW_BIT    2
`define CAUSE_COLD_BIT  3
`define CAUSE_RESET     4'h8

// pin must read low for this many clocks
`define PIN_MIN_CYCLES  12
`define PIN_COUNT_LAST  4'hb
// internal sources stretch the reset this long
`define HOLD_COUNT_LAST 4'hb

`endif

// ===== rtl/chip_reset_control_pkg.sv
/*
 * types of the chip reset controller.
 * assumes the params header for all numeric constants.
 */
package chip_reset_control_pkg;

    // gray along run -> hold -> release; release -> run changes both bits
    typedef enum logic [1:0] {
        RUN     = 2'b00,
        HOLD    = 2'b01,
        RELEASE = 2'b11
    } reset_state_t;

endpackage

// ===== rtl/chip_reset_control.sv
/*
 * chip reset controller: merges pin, watchdog and software reset
 * into one core reset, keeps cold-only registers, sets pll and
 * debug pin defaults, gates debug traffic and watchdog run.
 * assumes rstn is the power-on (cold) reset, synchronous to ref_clk,
 * and that watchdog and software requests come from ref_clk logic.
 */
`timescale 1ns/1ps
`include "chip_reset_control_params.svh"

module chip_reset_control
(
    input  wire logic        ref_clk,       // system clock 50 MHz
    input  wire logic        rstn,          // cold reset, active low
    input  wire logic        resetPinN,     // external reset pin
    input  wire logic        watchdogReset, // watchdog reset request
    input  wire logic        swResetReq,    // core software request
    input  wire logic        slowMode,      // low-speed clock mode
    input  wire logic        debugHalt,     // core in debug halt
    input  wire logic        debugReq,      // probe wants access
    input  wire logic [7:0]  addr,          // register byte address
    input  wire logic [31:0] wdata,         // write data
    input  wire logic        wr,            // write strobe
    input  wire logic        rd,            // read strobe
    output logic      [31:0] rdata,         // read data, next cycle
    output logic             coreResetN,    // warm reset to core
    output logic             vectorFetch,   // start at reset vector
    output logic             pllEnable,     // pll multiplier on
    output logic      [4:0]  debugPinFunc,  // 1 = pin in debug use
    output logic             debugGrant,    // probe access granted
    output logic             watchdogRun    // watchdog may count
);

    ////////////////////////////////////////////////////////////////
    // pin synchroniser and low-time filter

    logic       pinS1;
    logic       pinS2;
    logic [3:0] pinCount;
    logic       pinLow;
    logic       pinLong;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pinS1 <= 1'b1;
            pinS2 <= 1'b1;
        end
        else
        begin
            pinS1 <= resetPinN;
            pinS2 <= pinS1;
        end
    end

    assign pinLow = !pinS2;

    // saturates, so a pin held for long stays recognised
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || !pinLow)
            pinCount <= 4'h0;
        else if (pinCount != `PIN_COUNT_LAST)
            pinCount <= pinCount + 4'h1;
    end

    // twelfth low clock seen: accept the pulse  (see R4)
    assign pinLong = pinLow && (pinCount == `PIN_COUNT_LAST);

    ////////////////////////////////////////////////////////////////
    // source merge and sequencing

    chip_reset_control_pkg::reset_state_t state;
    chip_reset_control_pkg::reset_state_t next_state;

    logic [3:0] holdCount;
    logic       trigger;
    logic       holdDone;

    // any source starts a warm reset  (see R1) (see R16)
    // software requests are obeyed in slow mode too  (see R2)
    assign trigger  = pinLong || watchdogReset || swResetReq;
    assign holdDone = (holdCount == `HOLD_COUNT_LAST) && !pinLow;

    always_comb
    begin
        next_state = state;
        case (state)
            chip_reset_control_pkg::RUN:
                if (trigger)
                    next_state = chip_reset_control_pkg::HOLD;
            chip_reset_control_pkg::HOLD:
                if (holdDone)
                    next_state = chip_reset_control_pkg::RELEASE;
            // a request in the release cycle is not lost  (see R1)
            chip_reset_control_pkg::RELEASE:
                if (trigger)
                    next_state = chip_reset_control_pkg::HOLD;
                else
                    next_state = chip_reset_control_pkg::RUN;
            default:
                next_state = chip_reset_control_pkg::HOLD;
        endcase
    end

    // cold reset enters hold, so it also ends through release
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            state <= chip_reset_control_pkg::HOLD;
        else
            state <= next_state;
    end

    // hold stays while the pin is still low
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || state != chip_reset_control_pkg::HOLD)
            holdCount <= 4'h0;
        else if (holdCount != `HOLD_COUNT_LAST)
            holdCount <= holdCount + 4'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            coreResetN  <= 1'b0;
            vectorFetch <= 1'b0;
        end
        else
        begin
            coreResetN  <= (next_state != chip_reset_control_pkg::HOLD);
            // one pulse as the core leaves reset  (see R9)
            vectorFetch <= (next_state == chip_reset_control_pkg::RELEASE);
        end
    end

    ////////////////////////////////////////////////////////////////
    // register decode

    logic       warmActive;
    logic       wrControl;
    logic       wrCause;
    logic       wrSecurity;
    logic [3:0] causeFlags;
    logic       flashSecure;
    logic [3:0] causeSet;
    logic [31:0] readMux;

    // ram is not cleared or held here; software must reload it
    // (see R10)
    assign warmActive = (state == chip_reset_control_pkg::HOLD);
    assign wrControl  = wr && (addr == `ADDR_CONTROL) && !warmActive;
    assign wrCause    = wr && (addr == `ADDR_CAUSE);
    assign wrSecurity = wr && (addr == `ADDR_SECURITY);

    assign causeSet = {1'b0,
                       swResetReq,
                       watchdogReset,
                       pinLong} & {4{state != chip_reset_control_pkg::HOLD}};

    ////////////////////////////////////////////////////////////////
    // warm-reset registers: pll select and debug pin function

    // both return to defaults on every reset  (see R6)
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || warmActive)
        begin
            pllEnable    <= 1'b0;          // see R8
            debugPinFunc <= `PINS_RESET;   // see R13
        end
        else if (wrControl)
        begin
            pllEnable    <= wdata[`CTRL_PLL_BIT];
            // early reassignment may lock the probe out  (see R14)
            debugPinFunc <= wdata[`CTRL_PINS_MSB:`CTRL_PINS_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////
    // cold-only registers: reset cause and flash security

    // write one to clear; a new cause in that cycle still sets
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            causeFlags <= `CAUSE_RESET;    // see R7
        else
            causeFlags <= (causeFlags & ~({4{wrCause}} & wdata[3:0]))
                          | causeSet;     // see R16
    end

    // untouched by warm reset  (see R7)
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            flashSecure <= 1'b0;
        else if (wrSecurity)
            flashSecure <= wdata[0];
    end

    ////////////////////////////////////////////////////////////////
    // debug gating and watchdog run

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            debugGrant  <= 1'b0;
            watchdogRun <= 1'b0;
        end
        else
        begin
            // no probe traffic while the pin is held  (see R11)
            // a probe stops at the vector via a software reset
            // (see R12)
            debugGrant  <= debugReq && !pinLow;
            // halt freezes only the watchdog  (see R15)
            watchdogRun <= !debugHalt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read port

    always_comb
    begin
        readMux = 32'h0;
        case (addr)
            `ADDR_CONTROL:
            begin
                readMux[`CTRL_PLL_BIT] = pllEnable;
                readMux[`CTRL_PINS_MSB:`CTRL_PINS_LSB] = debugPinFunc;
            end
            `ADDR_CAUSE:
                readMux[3:0] = causeFlags;
            `ADDR_SECURITY:
                readMux[0] = flashSecure;
            `ADDR_STATUS:
                readMux[3:0] = {debugHalt, slowMode, !debugGrant, pinLow};
            default:
                readMux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || !rd)
            rdata <= 32'h0;
        else
            rdata <= readMux;
    end

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence runIdle;
        state == chip_reset_control_pkg::RUN;
    endsequence

    sequence leaveReset;
        $rose(coreResetN) && vectorFetch;
    endsequence

    pin_accept_a: assert property ( // see R4
        runIdle and (pinLong)
        |=> !coreResetN ##1 !coreResetN)
        else $error("long pin pulse did not reset the core");

    pin_short_a: assert property ( // see R4
        runIdle and (pinLow && pinCount < `PIN_COUNT_LAST
                     && !watchdogReset && !swResetReq)
        |=> coreResetN)
        else $error("short pin pulse reset the core");

    wdt_source_a: assert property ( // see R1
        runIdle and (watchdogReset)
        |=> !coreResetN ##0 causeFlags[`CAUSE_WDT_BIT])
        else $error("watchdog request not taken");

    sw_source_a: assert property ( // see R1
        runIdle and (swResetReq)
        |=> !coreResetN [*2] ##0 causeFlags[`CAUSE_SW_BIT])
        else $error("software request not taken");

    reset_stretch_a: assert property ( // see R16
        $fell(coreResetN) |-> !coreResetN [*8])
        else $error("core reset shorter than stretch");

    vector_start_a: assert property ( // see R9
        $rose(coreResetN) |-> leaveReset ##1 !vectorFetch)
        else $error("vector fetch not one pulse at release");

    pll_off_a: assert property ( // see R8
        leaveReset |-> !pllEnable)
        else $error("pll active when reset ends");

    pins_default_a: assert property ( // see R13
        leaveReset |-> debugPinFunc == `PINS_RESET)
        else $error("debug pins not in debug use after reset");

    debug_block_a: assert property ( // see R11
        pinLow |=> !debugGrant)
        else $error("probe granted while pin held");

    cause_kept_a: assert property ( // see R7
        !coreResetN && !wrCause
        |=> (causeFlags & $past(causeFlags)) == $past(causeFlags))
        else $error("cause flags lost in warm reset");

    wdt_halt_a: assert property ( // see R15
        debugHalt ##1 debugHalt |-> !watchdogRun)
        else $error("watchdog ran during halt");

    wdt_free_a: assert property ( // see R15
        coreResetN && !debugHalt |=> watchdogRun)
        else $error("watchdog stopped outside halt");

    grant_open_a: assert property ( // see R11
        coreResetN && debugReq && !pinLow |=> debugGrant)
        else $error("probe refused with pin released");

    control_reset_a: assert property ( // see R6
        warmActive |=> !pllEnable && debugPinFunc == `PINS_RESET)
        else $error("control not at defaults during reset");

    security_kept_a: assert property ( // see R7
        !wrSecurity |=> $stable(flashSecure))
        else $error("security bit changed without write");

    pin_cause_a: assert property ( // see R16
        runIdle and (pinLong) |=> causeFlags[`CAUSE_PIN_BIT])
        else $error("pin reset not recorded");

    // core reset length in cycles; saturates, only the minimum matters
    logic [3:0] lowRun;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || coreResetN)
            lowRun <= 4'h0;
        else if (lowRun != 4'hf)
            lowRun <= lowRun + 4'h1;
    end

    reset_length_a: assert property ( // see R4
        $rose(coreResetN) |-> {28'h0, lowRun} >= `PIN_MIN_CYCLES)
        else $error("core reset shorter than twelve cycles");

endmodule // chip_reset_control

// ===== tb/reset_probe_model.sv
/* far side: external reset driver and debug probe.
   assumes ref_clk from the bench; the pin is always driven. */
`timescale 1ns/1ps
module reset_probe_model
#(
    parameter int PWR_CYCLES = 16 // shortened settle time
)
(
    input  wire logic ref_clk,   // system clock
    output logic      resetPinN, // external reset pin
    output logic      debugReq   // probe access request
);
    initial
    begin
        resetPinN = 1'b0;
        debugReq  = 1'b0;
        repeat (PWR_CYCLES) @(posedge ref_clk);
        resetPinN <= 1'b1;
    end

    // supply and oscillator taken as stable here
    task automatic pin_pulse(input int n);
        @(posedge ref_clk);
        resetPinN <= 1'b0;
        repeat (n) @(posedge ref_clk);
        resetPinN <= 1'b1;
    endtask

    task automatic set_req(input logic v);
        @(posedge ref_clk);
        debugReq <= v;
    endtask
endmodule // reset_probe_model

// ===== tb/testbench.sv
/* self-checking bench of the chip reset controller.
   assumes the params header macros and a 50 MHz ref_clk. */
`timescale 1ns/1ps
`include "chip_reset_control_params.svh"
module testbench;
    logic        ref_clk;
    logic        rstn;
    logic        watchdogReset;
    logic        swResetReq;
    logic        slowMode;
    logic        debugHalt;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        coreResetN;
    logic        vectorFetch;
    logic        pllEnable;
    logic [4:0]  debugPinFunc;
    logic        debugGrant;
    logic        watchdogRun;
    logic        resetPinN;
    logic        debugReq;
    int          failures;
    int          n_tests;

    chip_reset_control dut_u (.ref_clk(ref_clk), .rstn(rstn),
        .resetPinN(resetPinN), .watchdogReset(watchdogReset),
        .swResetReq(swResetReq), .slowMode(slowMode),
        .debugHalt(debugHalt), .debugReq(debugReq), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .coreResetN(coreResetN), .vectorFetch(vectorFetch),
        .pllEnable(pllEnable), .debugPinFunc(debugPinFunc),
        .debugGrant(debugGrant), .watchdogRun(watchdogRun));

    reset_probe_model partner_u (.ref_clk(ref_clk),
        .resetPinN(resetPinN), .debugReq(debugReq));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // bounded wait, a hang shows up as a coreResetN mismatch
    task automatic wait_core(input logic v);
        for (int i = 0; i < 40 && coreResetN !== v; i++) tick(1);
        chk("coreResetN", {31'h0, v}, {31'h0, coreResetN});
    endtask

    task automatic wait_release();
        wait_core(1'b1);
        chk("vectorFetch", 32'h1, {31'h0, vectorFetch});
        tick(1);
        chk("vectorFetch", 32'h0, {31'h0, vectorFetch});
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_cold();
        logic [31:0] d;
        chk("pllEnable", 32'h0, {31'h0, pllEnable});
        chk("pins", {27'h0, `PINS_RESET}, {27'h0, debugPinFunc});
        wait_release();
        reg_rd(`ADDR_CAUSE, d);
        chk("cause", 32'h8, d);
        $display("test cold done");
    endtask

    task automatic t_regs();
        logic [31:0] d;
        reg_wr(`ADDR_CONTROL, 32'h0a1);
        tick(1);
        chk("pllEnable", 32'h1, {31'h0, pllEnable});
        chk("pins", 32'h0a, {27'h0, debugPinFunc});
        reg_wr(`ADDR_SECURITY, 32'h1);
        reg_rd(8'h10, d);
        chk("unmapped", 32'h0, d);
        partner_u.set_req(1'b1);
        tick(2);
        chk("debugGrant", 32'h1, {31'h0, debugGrant});
        $display("test regs done");
    endtask

    task automatic t_short();
        partner_u.pin_pulse(11);
        tick(6);
        chk("coreResetN", 32'h1, {31'h0, coreResetN});
        $display("test short pulse done");
    endtask

    task automatic t_pin();
        logic [31:0] d;
        fork
            partner_u.pin_pulse(20);
        join_none
        tick(10);
        chk("debugGrant", 32'h0, {31'h0, debugGrant});
        reg_rd(`ADDR_STATUS, d);
        chk("status", 32'h3, d);
        wait_core(1'b0);
        wait_release();
        chk("pllEnable", 32'h0, {31'h0, pllEnable});
        reg_rd(`ADDR_CONTROL, d);
        chk("control", 32'h1f0, d);
        reg_rd(`ADDR_CAUSE, d);
        chk("cause", 32'h9, d);
        reg_rd(`ADDR_SECURITY, d);
        chk("security", 32'h1, d);
        reg_wr(`ADDR_CAUSE, 32'hf);
        reg_rd(`ADDR_CAUSE, d);
        chk("cause", 32'h0, d);
        $display("test pin reset done");
    endtask

    task automatic t_internal();
        logic [31:0] d;
        for (int s = 1; s < 3; s++)
        begin
            @(posedge ref_clk);
            watchdogReset <= (s == 1);
            swResetReq    <= (s == 2);
            @(posedge ref_clk);
            watchdogReset <= 1'b0;
            swResetReq    <= 1'b0;
            wait_core(1'b0);
            wait_release();
            reg_rd(`ADDR_CAUSE, d);
            chk("cause", 32'h1 << s, d);
            reg_wr(`ADDR_CAUSE, 32'hf);
        end
        $display("test internal sources done");
    endtask

    task automatic t_halt();
        @(posedge ref_clk);
        debugHalt <= 1'b1;
        tick(2);
        chk("watchdogRun", 32'h0, {31'h0, watchdogRun});
        @(posedge ref_clk);
        debugHalt <= 1'b0;
        tick(2);
        chk("watchdogRun", 32'h1, {31'h0, watchdogRun});
        $display("test halt done");
    endtask

    task automatic t_recold();
        logic [31:0] d;
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        wait_release();
        reg_rd(`ADDR_SECURITY, d);
        chk("security", 32'h0, d);
        reg_rd(`ADDR_CAUSE, d);
        chk("cause", {28'h0, `CAUSE_RESET}, d);
        $display("test cold again done");
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end

    initial
    begin
        rstn          = 1'b0;
        watchdogReset = 1'b0;
        swResetReq    = 1'b0;
        slowMode      = 1'b0; // software resets only at speed
        debugHalt     = 1'b0;
        addr          = 8'h00;
        wdata         = 32'h0;
        wr            = 1'b0;
        rd            = 1'b0;
        failures      = 0;
        n_tests       = 0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        tick(1);
        t_cold();
        t_regs();
        t_short();
        t_pin();
        t_internal();
        t_halt();
        t_recold();
        end_of_test();
    end
endmodule // testbench
